// ### common/swac_pkg.sv
package swac_pkg;

  // Part organisations
  typedef enum logic [1:0] {
    SWAC_CFG_X9,
    SWAC_CFG_X18,
    SWAC_CFG_X36
  } swac_cfg_t;

  localparam int DATA_W_MAX = 36;
  localparam int ADDR_W_MAX = 21;
  localparam int LANE_W = 9;
  localparam int NUM_LANES = 4;
  localparam int NIB_W = 4;
  localparam int BURST_LEN = 4;
  localparam int DATA_W_X9 = 9;
  localparam int DATA_W_X18 = 18;
  localparam int DATA_W_X36 = 36;
  localparam int ADDR_W_X9 = 21;
  localparam int ADDR_W_X18 = 20;
  localparam int ADDR_W_X36 = 19;
  localparam int CLK_PERIOD_NS = 40;

  localparam logic K_PHASE_RST = 1'b0;
  localparam logic WR_SLOT_RST = 1'b0;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [2:0] RD_LEFT_LOAD = 3'h3;

  function automatic int cfg_data_w(input swac_cfg_t cfg);
    case (cfg)
      SWAC_CFG_X9: cfg_data_w = DATA_W_X9;
      SWAC_CFG_X18: cfg_data_w = DATA_W_X18;
      default: cfg_data_w = DATA_W_X36;
    endcase
  endfunction

  function automatic int cfg_addr_w(input swac_cfg_t cfg);
    case (cfg)
      SWAC_CFG_X9: cfg_addr_w = ADDR_W_X9;
      SWAC_CFG_X18: cfg_addr_w = ADDR_W_X18;
      default: cfg_addr_w = ADDR_W_X36;
    endcase
  endfunction

  // Ones in the address bits that the organisation uses
  function automatic logic [ADDR_W_MAX-1:0] addr_mask(input swac_cfg_t cfg);
    logic [ADDR_W_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < ADDR_W_MAX; i++) begin
      m[i] = (i < cfg_addr_w(cfg));
    end
    addr_mask = m;
  endfunction

  // Per-bit write enable from active-low lane and nibble selects
  function automatic logic [DATA_W_MAX-1:0] bit_enable(input swac_cfg_t cfg, input logic nib_lo_n,
      input logic nib_hi_n, input logic [NUM_LANES-1:0] lane_n);
    logic [DATA_W_MAX-1:0] en;
    en = '0;
    for (int i = 0; i < DATA_W_MAX; i++) begin
      en[i] = !lane_n[i / LANE_W] && (i < cfg_data_w(cfg));
      if (cfg == SWAC_CFG_X9 && i < NIB_W) begin
        en[i] = en[i] && !nib_lo_n;
      end else if (cfg == SWAC_CFG_X9 && i < 2 * NIB_W) begin
        en[i] = en[i] && !nib_hi_n;
      end
    end
    bit_enable = en;
  endfunction

endpackage

// ### hw/swac_subarray.sv
`timescale 1ns/1ps
`default_nettype none

module swac_subarray #(
  parameter int DW = 36,
  parameter int AW = 19
) (
  // Clock
  input wire logic clk_i,
  // Write side
  input wire logic we_i,
  input wire logic [DW-1:0] wbit_en_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read side
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Masked bits keep their stored value
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= (mem[waddr_i] & ~wbit_en_i) | (wdata_i & wbit_en_i);
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

`default_nettype wire

// ### hw/swac_core.sv
// Overview of operation
// - Write data is taken on both the positive and the negative input clock edges of an active write, 9, 18 or 36 bits wide.
// - A low write port select sampled on a positive clock edge of the write slot (every second positive edge) starts a write.
// - A high write port select on a positive edge starts no write; data inputs are taken only during a running write burst.
// - In the nine-bit part the low nibble select masks bits 3 to 0 and the high one bits 7 to 4.
// - Each nibble select is taken on the edge of its own data beat and a deselected nibble is not written.
// - Byte lane select n masks bits 9n+8 down to 9n, four selects covering bits 35 to 0.
// - A lane whose select is high leaves the stored bits unchanged.
// - Lane selects are taken on the edge of their own data beat so masking may change per beat.
// - The address is taken only on positive clock edges for reads and writes.
// - One address bus is shared in time between read and write.
// - The address is 21, 20 or 19 bits for the 9, 18 and 36 bit parts.
// - The address is ignored on an edge whose port select is high.
// - A low read port select on a positive edge of the read slot (every second positive edge) starts a read of four sequential words.
// - Accesses start only on positive clock edges.
`timescale 1ns/1ps
`default_nettype none

module swac_core #(
  parameter swac_pkg::swac_cfg_t CFG = swac_pkg::SWAC_CFG_X36
) (
  // Clock and reset; each clk_i rising edge is one input clock edge
  input wire logic clk_i,
  input wire logic srst_i,
  // Port selects
  input wire logic write_port_select_n_i,
  input wire logic read_port_select_n_i,
  // Address and write data
  input wire logic [swac_pkg::ADDR_W_MAX-1:0] address_i,
  input wire logic [swac_pkg::DATA_W_MAX-1:0] wr_data_i,
  // Write masks
  input wire logic nibble_mask_lo_n_i,
  input wire logic nibble_mask_hi_n_i,
  input wire logic lane_mask0_n_i,
  input wire logic lane_mask1_n_i,
  input wire logic lane_mask2_n_i,
  input wire logic lane_mask3_n_i,
  // Read burst and status
  output logic [swac_pkg::DATA_W_MAX-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic k_phase_o,
  output logic wr_busy_o
);
  import swac_pkg::*;

  localparam int DW = cfg_data_w(CFG);
  localparam int AW = cfg_addr_w(CFG);

  typedef struct packed {
    logic k_phase;
    logic wr_slot;
    logic wr_busy;
    logic [1:0] wr_beat;
    logic [ADDR_W_MAX-1:0] wr_addr;
    logic rd_load;
    logic [2:0] rd_left;
    logic [3*DATA_W_MAX-1:0] rd_buf;
    logic [DATA_W_MAX-1:0] rd_data;
    logic rd_valid;
  } swac_state_t;

  swac_state_t st;
  swac_state_t next_st;

  logic k_edge;
  logic wr_start;
  logic rd_start;
  logic [ADDR_W_MAX-1:0] addr_used;
  logic [DATA_W_MAX-1:0] bit_en;
  logic [BURST_LEN-1:0] sub_we;
  logic [DATA_W_MAX-1:0] sub_rdata [BURST_LEN];

  assign k_edge = (st.k_phase == K_PHASE_RST);
  assign wr_start = k_edge && st.wr_slot && !write_port_select_n_i;
  assign rd_start = k_edge && !st.wr_slot && !read_port_select_n_i;
  assign addr_used = address_i & addr_mask(CFG);
  assign bit_en = bit_enable(CFG, nibble_mask_lo_n_i, nibble_mask_hi_n_i,
      {lane_mask3_n_i, lane_mask2_n_i, lane_mask1_n_i, lane_mask0_n_i});

  always_comb begin
    for (int b = 0; b < BURST_LEN; b++) begin
      sub_we[b] = st.wr_busy && (st.wr_beat == b[1:0]);
    end
  end

  // Four sub-arrays, one per burst word
  for (genvar g = 0; g < BURST_LEN; g++) begin : g_sub
    logic [DW-1:0] rdata;
    swac_subarray #(
      .DW(DW),
      .AW(AW)
    ) u_sub (
      .clk_i(clk_i),
      .we_i(sub_we[g]),
      .wbit_en_i(bit_en[DW-1:0]),
      .waddr_i(st.wr_addr[AW-1:0]),
      .wdata_i(wr_data_i[DW-1:0]),
      .re_i(rd_start),
      .raddr_i(addr_used[AW-1:0]),
      .rdata_o(rdata)
    );
    if (DW < DATA_W_MAX) begin : g_pad
      assign sub_rdata[g] = {{(DATA_W_MAX-DW){1'b0}}, rdata};
    end else begin : g_full
      assign sub_rdata[g] = rdata;
    end
  end

  always_comb begin
    next_st = st;
    next_st.k_phase = !st.k_phase;
    if (k_edge) begin
      next_st.wr_slot = !st.wr_slot;
    end
    // Write beats
    if (st.wr_busy) begin
      next_st.wr_beat = st.wr_beat + 2'h1;
      if (st.wr_beat == BEAT_LAST) begin
        next_st.wr_busy = 1'b0;
      end
    end
    if (wr_start) begin
      next_st.wr_busy = 1'b1;
      next_st.wr_beat = 2'h0;
      next_st.wr_addr = addr_used;
    end
    // Read burst out
    next_st.rd_load = rd_start;
    if (st.rd_load) begin
      next_st.rd_data = sub_rdata[0];
      next_st.rd_buf = {sub_rdata[3], sub_rdata[2], sub_rdata[1]};
      next_st.rd_left = RD_LEFT_LOAD;
      next_st.rd_valid = 1'b1;
    end else if (st.rd_left != 3'h0) begin
      next_st.rd_data = st.rd_buf[DATA_W_MAX-1:0];
      next_st.rd_buf = {{DATA_W_MAX{1'b0}}, st.rd_buf[3*DATA_W_MAX-1:DATA_W_MAX]};
      next_st.rd_left = st.rd_left - 3'h1;
      next_st.rd_valid = 1'b1;
    end else begin
      next_st.rd_valid = 1'b0;
    end
    if (srst_i) begin
      next_st = '0;
      next_st.k_phase = K_PHASE_RST;
      next_st.wr_slot = WR_SLOT_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign rd_data_o = st.rd_data;
  assign rd_valid_o = st.rd_valid;
  assign k_phase_o = st.k_phase;
  assign wr_busy_o = st.wr_busy;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_wr_start_busy;
    wr_start |=> st.wr_busy && st.wr_beat == 2'h0;
  endproperty
  a_wr_start_busy: assert property (p_wr_start_busy) else $error("write did not start");

  property p_wr_deselect_ignored;
    (k_edge && st.wr_slot && write_port_select_n_i && !st.wr_busy) |=> !st.wr_busy;
  endproperty
  a_wr_deselect_ignored: assert property (p_wr_deselect_ignored) else $error("deselected write started");

  property p_wr_four_beats;
    wr_start |=> (st.wr_busy && sub_we != '0) [*4] ##1 (!st.wr_busy || $past(wr_start));
  endproperty
  a_wr_four_beats: assert property (p_wr_four_beats) else $error("write burst not four beats");

  property p_no_write_idle;
    !st.wr_busy |-> sub_we == '0;
  endproperty
  a_no_write_idle: assert property (p_no_write_idle) else $error("array written while idle");

  property p_nibble_mask;
    (CFG == SWAC_CFG_X9 && !lane_mask0_n_i) |->
      bit_en[3:0] == {4{!nibble_mask_lo_n_i}} && bit_en[7:4] == {4{!nibble_mask_hi_n_i}};
  endproperty
  a_nibble_mask: assert property (p_nibble_mask) else $error("nibble mask wrong");

  property p_lane_mask;
    lane_mask1_n_i && (CFG == SWAC_CFG_X36) |-> bit_en[17:9] == 9'h000 && bit_en[8] == !lane_mask0_n_i;
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("lane mask wrong");

  property p_addr_capture;
    wr_start |=> st.wr_addr == ($past(address_i) & addr_mask(CFG));
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("write address not captured");

  property p_addr_ignored;
    !wr_start |=> $stable(st.wr_addr);
  endproperty
  a_addr_ignored: assert property (p_addr_ignored) else $error("address taken while deselected");

  property p_access_on_k;
    (wr_start || rd_start) |-> st.k_phase == K_PHASE_RST;
  endproperty
  a_access_on_k: assert property (p_access_on_k) else $error("access on negative edge");

  property p_shared_bus;
    !(wr_start && rd_start);
  endproperty
  a_shared_bus: assert property (p_shared_bus) else $error("read and write on same edge");

  property p_read_burst;
    rd_start |=> (!rd_valid_o || $past(rd_start, 5)) ##1 rd_valid_o [*4]
      ##1 (!rd_valid_o || $past(rd_start, 2));
  endproperty
  a_read_burst: assert property (p_read_burst) else $error("read burst not four words");

  property p_addr_width;
    (st.wr_addr & ~addr_mask(CFG)) == '0;
  endproperty
  a_addr_width: assert property (p_addr_width) else $error("unused address bits set");

  c_write: cover property (wr_start ##4 !st.wr_busy);
  c_read: cover property (rd_start ##5 rd_valid_o);
  c_back_to_back_wr: cover property (wr_start ##4 wr_start);
  c_rd_wr: cover property (rd_start ##2 wr_start);

endmodule

`default_nettype wire

// ### test/swac_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module swac_ctrl_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pins toward the memory
  output logic write_port_select_n_o,
  output logic read_port_select_n_o,
  output logic [20:0] address_o,
  output logic [35:0] wr_data_o,
  output logic [5:0] mask_n_o
);
  int unsigned e;

  // Index of the coming edge
  always @(posedge clk_i) e <= srst_i ? 0 : e + 1;

  initial begin
    write_port_select_n_o = 1'b1;
    read_port_select_n_o = 1'b1;
    address_o = '0;
    wr_data_o = '0;
    mask_n_o = '1;
  end

  task automatic slot(input int s);
    do @(negedge clk_i); while (e % 4 != s);
  endtask

  task automatic write(input logic [20:0] a, input logic [143:0] d, input logic [23:0] m, input int s);
    slot(s);
    write_port_select_n_o = 1'b0;
    address_o = a;
    for (int b = 0; b < 4; b++) begin
      @(negedge clk_i);
      write_port_select_n_o = 1'b1;
      address_o = ~address_o;
      wr_data_o = d[36*b+:36];
      mask_n_o = m[6*b+:6];
    end
    @(negedge clk_i);
    wr_data_o = ~wr_data_o;
    mask_n_o = ~mask_n_o;
  endtask

  task automatic read(input logic [20:0] a);
    slot(0);
    read_port_select_n_o = 1'b0;
    address_o = a;
    @(negedge clk_i);
    read_port_select_n_o = 1'b1;
    address_o = ~address_o;
  endtask
endmodule

`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import swac_pkg::*;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wsel_n, rsel_n, rd_valid, k_phase, wr_busy;
  logic [20:0] addr;
  logic [35:0] wdata, rd_data;
  logic [5:0] mask_n;
  logic [31:0] seed = 32'h0000CF56;
  logic [143:0] mem [logic [18:0]];
  logic rd_valid9;
  logic [35:0] rd_data9;
  logic [35:0] mem9 [logic [18:0]];
  int busy_cnt = 0;
  int bad [3] = '{0, 1, 3};
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #20 clk_i = ~clk_i;

  swac_core #(.CFG(SWAC_CFG_X36)) dut_u (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .write_port_select_n_i(wsel_n),
    .read_port_select_n_i(rsel_n),
    .address_i(addr),
    .wr_data_i(wdata),
    .nibble_mask_lo_n_i(mask_n[4]),
    .nibble_mask_hi_n_i(mask_n[5]),
    .lane_mask0_n_i(mask_n[0]),
    .lane_mask1_n_i(mask_n[1]),
    .lane_mask2_n_i(mask_n[2]),
    .lane_mask3_n_i(mask_n[3]),
    .rd_data_o(rd_data),
    .rd_valid_o(rd_valid),
    .k_phase_o(k_phase),
    .wr_busy_o(wr_busy)
  );

  // Nine-bit part on the same pins; top address bits follow the key
  swac_core #(.CFG(SWAC_CFG_X9)) dut9_u (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .write_port_select_n_i(wsel_n),
    .read_port_select_n_i(rsel_n),
    .address_i({addr[1:0], addr[18:0]}),
    .wr_data_i(wdata),
    .nibble_mask_lo_n_i(mask_n[4]),
    .nibble_mask_hi_n_i(mask_n[5]),
    .lane_mask0_n_i(mask_n[0]),
    .lane_mask1_n_i(mask_n[1]),
    .lane_mask2_n_i(mask_n[2]),
    .lane_mask3_n_i(mask_n[3]),
    .rd_data_o(rd_data9),
    .rd_valid_o(rd_valid9),
    .k_phase_o(),
    .wr_busy_o()
  );

  swac_ctrl_model ctrl_u (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .write_port_select_n_o(wsel_n),
    .read_port_select_n_o(rsel_n),
    .address_o(addr),
    .wr_data_o(wdata),
    .mask_n_o(mask_n)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [18:0] key(input int i);
    return {i[2], 16'h0000, i[1:0]};
  endfunction

  // Lanes with a high select keep the old bits; nibble selects unused here
  function automatic logic [143:0] merge(input logic [143:0] o, input logic [143:0] d, input logic [23:0] m);
    merge = o;
    for (int b = 0; b < 4; b++)
      for (int k = 0; k < 4; k++)
        if (!m[6*b+k]) merge[36*b+9*k+:9] = d[36*b+9*k+:9];
  endfunction

  // Nine-bit words: bit 8 by lane 0, bits 7:0 by lane 0 and their nibble select
  function automatic logic [35:0] merge9(input logic [35:0] o, input logic [143:0] d, input logic [23:0] m);
    merge9 = o;
    for (int b = 0; b < 4; b++)
      for (int i = 0; i < 9; i++)
        if (!m[6*b] && (i == 8 || !m[6*b+4+i/4])) merge9[9*b+i] = d[36*b+i];
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [18:0] k, input int s, input logic [23:0] m);
    logic [143:0] d;
    for (int b = 0; b < 4; b++) d[36*b+:36] = 36'({rnd(), rnd()});
    busy_cnt = 0;
    ctrl_u.write({2'(rnd()), k}, d, m, s);
    chk("wr_busy", 36'(busy_cnt), 36'((s == 2) ? BURST_LEN : 0));
    if (s == 2) mem[k] = merge(mem[k], d, m);
    if (s == 2) mem9[k] = merge9(mem9[k], d, m);
    @(negedge clk_i);
    chk("wr_busy_end", wr_busy, 0);
  endtask

  task automatic rd_chk(input logic [18:0] k);
    ctrl_u.read({2'(rnd()), k});
    chk("rd_valid_early", rd_valid, 0);
    for (int w = 0; w < 4; w++) begin
      @(negedge clk_i);
      chk("rd_valid", rd_valid, 1);
      chk("rd_word", rd_data, mem[k][36*w+:36]);
      chk("rd_valid9", rd_valid9, 1);
      chk("rd_word9", rd_data9, {27'h0000000, mem9[k][9*w+:9]});
    end
    @(negedge clk_i);
    chk("rd_valid_end", rd_valid, 0);
  endtask

  // Beats seen with the write port busy
  always @(negedge clk_i) if (wr_busy === 1'b1) busy_cnt++;

  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    logic [23:0] m;
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    chk("k_phase", k_phase, 0);
    chk("rd_valid", rd_valid, 0);
    for (int i = 0; i < 8; i++) wr(key(i), 2, 24'h000000);
    for (int i = 0; i < 8; i++) rd_chk(key(i));
    $display("test fill done");
    wr(key(0), 2, 24'hFFFFFF);
    wr(key(1), 2, {6'h30, 6'h0F, 6'h00, 6'h3F});
    rd_chk(key(0));
    rd_chk(key(1));
    $display("test mask corners done");
    for (int n = 0; n < 60; n++) begin
      m = 24'(rnd() & rnd());
      case (rnd() % 4)
        0, 1: wr(key(rnd() % 8), 2, m);
        2: rd_chk(key(rnd() % 8));
        default: wr(key(rnd() % 8), bad[rnd() % 3], m);
      endcase
    end
    for (int i = 0; i < 8; i++) rd_chk(key(i));
    $display("test random done");
    print_verdict();
  end
endmodule

`default_nettype wire
